// [inc/adc_pkg.sv]
`default_nettype none

package adc_pkg;

   // internal bus
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned RDATA_W = 16;

   localparam logic [ADDR_W-1:0] MODE_ADDR    = 16'hff8d;
   localparam logic [ADDR_W-1:0] CHAN_ADDR    = 16'hff8e;
   localparam logic [ADDR_W-1:0] WIDE_LO_ADDR = 16'hff06;
   localparam logic [ADDR_W-1:0] WIDE_HI_ADDR = 16'hff07;
   localparam logic [ADDR_W-1:0] BYTE_ADDR    = 16'hff8c;

   // mode register layout
   localparam logic [2:0] RUN_BIT    = 3'h7;
   localparam logic [2:0] CMP_BIT    = 3'h0;
   localparam int unsigned TIME_HI   = 6;
   localparam int unsigned TIME_LO   = 3;
   localparam int unsigned RANGE_HI  = 2;
   localparam int unsigned RANGE_LO  = 1;
   localparam logic [1:0] RANGE_LOW = 2'h1;

   localparam logic [BYTE_W-1:0] MODE_RESET = 8'h00;

   // channel select
   localparam int unsigned CHAN_W = 3;
   localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
   localparam logic [CHAN_W-1:0] CHAN_LAST  = 3'h5;

   // result
   localparam int unsigned RES_W = 10;
   localparam int unsigned PAD_W = 6;
   localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
   localparam logic [RES_W-1:0] RES_MSB      = 10'h200;

   // conversion clock divisors indexed by the conversion-time field
   localparam int unsigned DIV_W = 5;
   localparam logic [DIV_W-1:0] DIV_TABLE [0:15] = '{
      5'h0c, 5'h08, 5'h06, 5'h04, 5'h03, 5'h02, 5'h10, 5'h10,
      5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10};

   // sampling length in conversion clocks: 22 or 40 clocks total less 10 bit steps
   localparam logic [DIV_W-1:0] SAMPLE_FAD_NORM = 5'h0c;
   localparam logic [DIV_W-1:0] SAMPLE_FAD_LOW  = 5'h1e;

   // comparator settle time
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SETTLE_NS     = 1000;
   localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_W      = 7;

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_t;

endpackage : adc_pkg

`default_nettype wire

// [design/approximation_step.sv]
`default_nettype none

module approximation_step (
   input  wire logic                      mclk,
   input  wire logic                      reset,
   input  wire logic                      start,
   input  wire logic                      decide,
   input  wire logic                      comparator_high,
   output logic      [adc_pkg::RES_W-1:0] trial_code,
   output logic                           last_bit,
   output logic      [adc_pkg::RES_W-1:0] final_code
);
   import adc_pkg::*;

   logic [RES_W-1:0] sar_q;
   logic [RES_W-1:0] sar_d;
   logic [RES_W-1:0] mask_q;
   logic [RES_W-1:0] mask_d;
   logic [RES_W-1:0] kept;

   // drop the trial bit when the sampled level is below the tap
   assign kept       = comparator_high ? sar_q : (sar_q & ~mask_q);
   assign final_code = kept;
   assign last_bit   = mask_q[0];
   assign trial_code = sar_q;

   assign sar_d  = start ? RES_MSB : (decide ? (kept | (mask_q >> 1)) : sar_q);
   assign mask_d = start ? RES_MSB : (decide ? (mask_q >> 1) : mask_q);

   always_ff @(posedge mclk) begin
      if (reset) begin
         sar_q  <= RESULT_RESET;
         mask_q <= RESULT_RESET;
      end else begin
         sar_q  <= sar_d;
         mask_q <= mask_d;
      end
   end

endmodule : approximation_step

`default_nettype wire

// [design/sar_adc_control.sv]
// What this block does
// - while running, convert the selected channel repeatedly at 10 bits, interrupt each end.
// - approximation register decides bits from the MSB, then transfers to the result.
// - wide view reloaded each end, result in upper ten bits, low six zero.
// - byte view reloaded each end with the upper eight result bits.
// - sample the input at conversion start, hold it until conversion finishes.
// - controller governs timing, start and stop, and raises the end interrupt.
// - mode register takes bit and byte writes; run bit7, time bits 6-3, range bits 2-1, comparator bit0.
// - any reset clears the mode register: conversion stopped, comparator off.
// - run bit 0 stops conversion, 1 enables it.
// - both off is fully powered down; comparator alone waits; run always converts.
// - comparator settles in 1 us; first result before that must be discarded.
// - mode writes insert a wait cycle; not while peripheral clock stopped.
// - result view reads insert a wait cycle; not while peripheral clock stopped.
// - wide view puts upper eight bits at high byte, low two at lower byte top.
// - three-bit channel select picks inputs 0 to 5; codes 6 and 7 prohibited.
`default_nettype none

module sar_adc_control (
   input  wire logic                         mclk,
   input  wire logic                         reset,
   input  wire logic [adc_pkg::ADDR_W-1:0]   bus_addr,
   input  wire logic                         bus_wr,
   input  wire logic                         bus_bit_wr,
   input  wire logic [2:0]                   bus_bit_sel,
   input  wire logic                         bus_bit_val,
   input  wire logic [adc_pkg::BYTE_W-1:0]   bus_wdata,
   input  wire logic                         bus_rd,
   output logic      [adc_pkg::RDATA_W-1:0]  bus_rdata,
   output logic                              bus_wait,
   input  wire logic                         comparator_high,
   output logic                              comparator_power,
   output logic                              sample_hold_sample,
   output logic      [adc_pkg::RES_W-1:0]    tap_code,
   output logic      [adc_pkg::CHAN_W-1:0]   channel_select,
   output logic                              channel_valid,
   output logic                              conversion_end_irq,
   output logic                              result_suspect
);
   import adc_pkg::*;

   conv_state_t         state_q;
   conv_state_t         state_d;
   logic [BYTE_W-1:0]   mode_q;
   logic [BYTE_W-1:0]   mode_d;
   logic [CHAN_W-1:0]   chan_q;
   logic [BYTE_W-1:0]   chan_byte;
   logic [RES_W-1:0]    result_q;
   logic [RDATA_W-1:0]  rdata_q;
   logic                wait_q;
   logic                irq_q;
   logic [DIV_W-1:0]    div_cnt_q;
   logic [DIV_W-1:0]    phase_cnt_q;
   logic [SETTLE_W-1:0] settle_cnt_q;
   logic                unsettled_q;
   logic                suspect_q;

   // ---------------- register access ----------------
   logic                mode_sel;
   logic                chan_sel;
   logic                view_sel;
   logic                any_wr;
   logic                acc_wait;
   logic                mode_take;
   logic                chan_take;
   logic                rd_take;
   logic [RDATA_W-1:0]  wide_view;
   logic [RDATA_W-1:0]  byte_view;
   logic [RDATA_W-1:0]  read_mux;

   assign mode_sel = (bus_addr == MODE_ADDR);
   assign chan_sel = (bus_addr == CHAN_ADDR);
   assign view_sel = (bus_addr == WIDE_LO_ADDR) || (bus_addr == WIDE_HI_ADDR) || (bus_addr == BYTE_ADDR);
   assign any_wr   = bus_wr || bus_bit_wr;

   // first cycle of a waited access stalls the cpu for exactly one cycle
   assign acc_wait  = (any_wr && (mode_sel || chan_sel)) || (bus_rd && view_sel);
   assign bus_wait  = acc_wait && !wait_q;
   assign mode_take = any_wr && mode_sel && !bus_wait;
   assign chan_take = any_wr && chan_sel && !bus_wait;
   assign rd_take   = bus_rd && !bus_wait;

   assign wide_view = {result_q, {PAD_W{1'b0}}};
   assign byte_view = {{(RDATA_W-BYTE_W){1'b0}}, result_q[RES_W-1 -: BYTE_W]};

   // the high byte address returns the upper eight result bits in the low lane, as the byte view address does
   assign read_mux = (bus_addr == WIDE_LO_ADDR) ? wide_view :
                     (bus_addr == WIDE_HI_ADDR) ? {{BYTE_W{1'b0}}, wide_view[RDATA_W-1 -: BYTE_W]} :
                     (bus_addr == BYTE_ADDR)    ? byte_view :
                     mode_sel                   ? {{BYTE_W{1'b0}}, mode_q} :
                     chan_sel                   ? {{(RDATA_W-CHAN_W){1'b0}}, chan_q} :
                     {RDATA_W{1'b0}};

   // single-bit manipulation changes one bit, byte write replaces all
   always_comb begin
      mode_d = mode_q;
      chan_byte = {{(BYTE_W-CHAN_W){1'b0}}, chan_q};
      if (bus_wr) begin
         mode_d    = bus_wdata;
         chan_byte = bus_wdata;
      end else begin
         mode_d[bus_bit_sel]    = bus_bit_val;
         chan_byte[bus_bit_sel] = bus_bit_val;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         mode_q  <= MODE_RESET;
         chan_q  <= CHAN_RESET;
         wait_q  <= 1'b0;
         rdata_q <= {RDATA_W{1'b0}};
      end else begin
         wait_q <= bus_wait;
         if (mode_take) begin
            mode_q <= mode_d;
         end
         if (chan_take) begin
            chan_q <= chan_byte[CHAN_W-1:0];
         end
         if (rd_take) begin
            rdata_q <= read_mux;
         end
      end
   end

   // ---------------- mode decode ----------------
   logic             run;
   logic             cmp_en;
   logic [3:0]       time_sel;
   logic [1:0]       range_sel;
   logic [DIV_W-1:0] divisor;
   logic [DIV_W-1:0] sample_len;
   logic             fad_tick;
   logic             settled;

   assign run       = mode_q[RUN_BIT];
   assign cmp_en    = mode_q[CMP_BIT];
   assign time_sel  = mode_q[TIME_HI:TIME_LO];
   assign range_sel = mode_q[RANGE_HI:RANGE_LO];

   // fields changed mid-conversion take effect at once; software stops first
   assign divisor    = DIV_TABLE[time_sel];
   assign sample_len = (range_sel == RANGE_LOW) ? SAMPLE_FAD_LOW : SAMPLE_FAD_NORM;
   assign fad_tick   = (state_q != ST_IDLE) && (div_cnt_q == divisor - 5'h01);

   // comparator draws current whenever either control bit is set
   assign comparator_power = run || cmp_en;
   assign settled          = (settle_cnt_q == SETTLE_W'(SETTLE_CYC));

   // ---------------- sequencer ----------------
   logic             sar_start;
   logic             sar_decide;
   logic             sar_last;
   logic [RES_W-1:0] sar_final;
   logic             conv_done;
   logic             restart;
   logic             enter_sample;

   // a new channel restarts sampling so no result mixes two inputs
   assign restart = run && chan_take && (state_q != ST_IDLE);

   always_comb begin
      state_d    = state_q;
      sar_start  = 1'b0;
      sar_decide = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (run) begin
               state_d = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            if (fad_tick && (phase_cnt_q == sample_len - 5'h01)) begin
               state_d   = ST_CONVERT;
               sar_start = 1'b1;
            end
         end
         ST_CONVERT: begin
            if (fad_tick) begin
               sar_decide = 1'b1;
               if (sar_last) begin
                  state_d = ST_SAMPLE;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (!run) begin
         state_d    = ST_IDLE;
         sar_start  = 1'b0;
         sar_decide = 1'b0;
      end else if (restart) begin
         state_d    = ST_SAMPLE;
         sar_start  = 1'b0;
         sar_decide = 1'b0;
      end
   end

   assign conv_done    = sar_decide && sar_last;
   assign enter_sample = (state_d == ST_SAMPLE) && ((state_q != ST_SAMPLE) || restart);

   approximation_step u_sar (
      .mclk            (mclk),
      .reset           (reset),
      .start           (sar_start),
      .decide          (sar_decide),
      .comparator_high (comparator_high),
      .trial_code      (tap_code),
      .last_bit        (sar_last),
      .final_code      (sar_final)
   );

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q      <= ST_IDLE;
         div_cnt_q    <= {DIV_W{1'b0}};
         phase_cnt_q  <= {DIV_W{1'b0}};
         result_q     <= RESULT_RESET;
         irq_q        <= 1'b0;
         settle_cnt_q <= {SETTLE_W{1'b0}};
         unsettled_q  <= 1'b0;
         suspect_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         if (fad_tick || enter_sample || (state_q == ST_IDLE)) begin
            div_cnt_q <= {DIV_W{1'b0}};
         end else begin
            div_cnt_q <= div_cnt_q + 5'h01;
         end
         if (enter_sample) begin
            phase_cnt_q <= {DIV_W{1'b0}};
         end else if (fad_tick && (state_q == ST_SAMPLE)) begin
            phase_cnt_q <= phase_cnt_q + 5'h01;
         end
         if (conv_done) begin
            result_q <= sar_final;
         end
         irq_q <= conv_done;
         if (!comparator_power) begin
            settle_cnt_q <= {SETTLE_W{1'b0}};
         end else if (!settled) begin
            settle_cnt_q <= settle_cnt_q + 7'h01;
         end
         // only the first conversion after a start is flagged as possibly taken too early
         if ((state_q == ST_IDLE) && (state_d == ST_SAMPLE)) begin
            unsettled_q <= !settled;
         end else if (conv_done) begin
            unsettled_q <= 1'b0;
         end
         if (conv_done) begin
            suspect_q <= unsettled_q;
         end
      end
   end

   assign sample_hold_sample = (state_q == ST_SAMPLE);
   assign channel_select     = chan_q;
   assign channel_valid      = (chan_q <= CHAN_LAST);
   assign conversion_end_irq = irq_q;
   assign result_suspect     = suspect_q;
   assign bus_rdata          = rdata_q;

   // ---------------- checks ----------------
   logic [3:0] decide_cnt_q;

   always_ff @(posedge mclk) begin
      if (reset || sar_start) begin
         decide_cnt_q <= 4'h0;
      end else if (sar_decide) begin
         decide_cnt_q <= decide_cnt_q + 4'h1;
      end
   end

   a_reset_clears_mode: assert property (
      @(posedge mclk) reset |=> (mode_q == MODE_RESET) && (state_q == ST_IDLE) && !comparator_power)
      else $error("mode register not cleared by reset");

   a_stop_goes_idle: assert property (
      @(posedge mclk) disable iff (reset) !run |=> (state_q == ST_IDLE) && !conversion_end_irq)
      else $error("conversion continued with run bit low");

   a_irq_each_end: assert property (
      @(posedge mclk) disable iff (reset) conv_done |=> conversion_end_irq ##1 !conversion_end_irq)
      else $error("end interrupt not a single pulse after conversion");

   a_ten_decisions: assert property (
      @(posedge mclk) disable iff (reset) conv_done |-> (decide_cnt_q == 4'h9))
      else $error("conversion did not resolve ten bits");

   a_wide_view_load: assert property (
      @(posedge mclk) disable iff (reset) conv_done |=> (wide_view == {$past(sar_final), 6'h00}))
      else $error("wide view not loaded with result");

   a_byte_view_load: assert property (
      @(posedge mclk) disable iff (reset) conv_done |=> (byte_view[7:0] == $past(sar_final[9:2])))
      else $error("byte view not loaded with upper bits");

   a_hold_while_convert: assert property (
      @(posedge mclk) disable iff (reset)
      $rose(state_q == ST_CONVERT) |-> $past(sample_hold_sample) && !sample_hold_sample)
      else $error("conversion began without a sample phase");

   a_power_down: assert property (
      @(posedge mclk) disable iff (reset) (!run && !cmp_en) |-> !comparator_power ##1 (state_q == ST_IDLE))
      else $error("converter not fully stopped");

   a_settle_wait: assert property (
      @(posedge mclk) disable iff (reset) $rose(comparator_power) |=> !settled [*8])
      else $error("comparator reported settled too early");

   a_mode_write_wait: assert property (
      @(posedge mclk) disable iff (reset)
      (bus_wr && mode_sel && !wait_q) |-> bus_wait ##1 (!(bus_wr && mode_sel) || !bus_wait))
      else $error("mode write not stalled exactly one cycle");

   a_view_read_wait: assert property (
      @(posedge mclk) disable iff (reset) (bus_rd && view_sel && !wait_q) |-> bus_wait)
      else $error("result read not stalled");

   a_channel_range: assert property (
      @(posedge mclk) disable iff (reset) channel_valid |-> (channel_select <= 3'h5))
      else $error("prohibited channel reported valid");

   a_divider_period: assert property (
      @(posedge mclk) disable iff (reset) fad_tick |=> !fad_tick)
      else $error("conversion clock faster than half the peripheral clock");

endmodule : sar_adc_control

`default_nettype wire

// [tb/analog_front_model.sv]
`default_nettype none

module analog_front_model (
   input  wire logic                          mclk,
   input  wire logic                          comparator_power,
   input  wire logic                          sample_hold_sample,
   input  wire logic [adc_pkg::RES_W-1:0]     tap_code,
   input  wire logic [adc_pkg::CHAN_W-1:0]    channel_select,
   input  wire logic [6*adc_pkg::RES_W-1:0]   levels,
   output logic                               comparator_high
);
   timeunit 1ns;
   timeprecision 1ps;
   import adc_pkg::*;

   logic [RES_W-1:0] held_q;
   logic             junk_q = 1'b0;
   wire logic        chan_ok    = (channel_select <= CHAN_LAST);
   wire logic [RES_W-1:0] live_level = chan_ok ? levels[channel_select*RES_W +: RES_W] : RESULT_RESET;

   // tracks the selected input while sampling, freezes it while holding
   always @(posedge mclk) begin
      if (sample_hold_sample) begin
         held_q <= live_level;
      end
      junk_q <= ~junk_q;
   end

   // an unpowered comparator gives no usable decision, so it toggles
   assign comparator_high = comparator_power ? (held_q >= tap_code) : junk_q;
endmodule : analog_front_model

`default_nettype wire

// [tb/sar_adc_control_tb.sv]
`default_nettype none

module sar_adc_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import adc_pkg::*;

   localparam logic [6*RES_W-1:0] LEVELS = {10'h201, 10'h0aa, 10'h155, 10'h3ff, 10'h000, 10'h2b5};
   localparam int DIV_EXP [0:5] = '{12, 8, 6, 4, 3, 2};

   logic                 mclk;
   logic                 reset;
   logic [ADDR_W-1:0]    bus_addr;
   logic                 bus_wr;
   logic                 bus_bit_wr;
   logic [2:0]           bus_bit_sel;
   logic                 bus_bit_val;
   logic [BYTE_W-1:0]    bus_wdata;
   logic                 bus_rd;
   logic [RDATA_W-1:0]   bus_rdata;
   logic                 bus_wait;
   logic                 comparator_high;
   logic                 comparator_power;
   logic                 sample_hold_sample;
   logic [RES_W-1:0]     tap_code;
   logic [CHAN_W-1:0]    channel_select;
   logic                 channel_valid;
   logic                 conversion_end_irq;
   logic                 result_suspect;
   int                   fail_count = 0;
   int                   checked = 0;
   int                   waits;
   logic [RDATA_W-1:0]   rd_q;

   sar_adc_control i_sar_adc_control (
      .mclk(mclk), .reset(reset), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr),
      .bus_bit_sel(bus_bit_sel), .bus_bit_val(bus_bit_val), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .bus_wait(bus_wait), .comparator_high(comparator_high),
      .comparator_power(comparator_power), .sample_hold_sample(sample_hold_sample), .tap_code(tap_code),
      .channel_select(channel_select), .channel_valid(channel_valid),
      .conversion_end_irq(conversion_end_irq), .result_suspect(result_suspect));

   analog_front_model i_analog_front_model (
      .mclk(mclk), .comparator_power(comparator_power), .sample_hold_sample(sample_hold_sample),
      .tap_code(tap_code), .channel_select(channel_select), .levels(LEVELS),
      .comparator_high(comparator_high));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check16

   task automatic check_int(input int got, input int exp, input string what);
      checked++;
      if (got != exp) begin
         fail_count++;
         $display("MISMATCH at %0t: %s got %0d expected %0d", $time, what, got, exp);
      end
   endtask : check_int

   // request held until an edge sees bus_wait low, then released; data sampled one edge later
   task automatic access(input logic [15:0] addr, input logic wr, input logic rd, input logic bw,
                         input logic [2:0] sel, input logic [7:0] data);
      bus_addr    <= addr;
      bus_wr      <= wr;
      bus_rd      <= rd;
      bus_bit_wr  <= bw;
      bus_bit_sel <= sel;
      bus_bit_val <= data[0];
      bus_wdata   <= data;
      waits = 0;
      @(posedge mclk);
      while (bus_wait !== 1'b0 && waits < 4) begin
         waits++;
         @(posedge mclk);
      end
      bus_wr     <= 1'b0;
      bus_rd     <= 1'b0;
      bus_bit_wr <= 1'b0;
      @(posedge mclk);
      rd_q = bus_rdata;
   endtask : access

   task automatic rd(input logic [15:0] addr);
      access(addr, 1'b0, 1'b1, 1'b0, 3'h0, 8'h00);
   endtask : rd

   task automatic wr8(input logic [15:0] addr, input logic [7:0] data);
      access(addr, 1'b1, 1'b0, 1'b0, 3'h0, data);
   endtask : wr8

   task automatic bitw(input logic [15:0] addr, input logic [2:0] sel, input logic val);
      access(addr, 1'b0, 1'b0, 1'b1, sel, {7'h00, val});
   endtask : bitw

   // cycles up to the next end pulse, and how many of them were spent sampling
   task automatic wait_irq(output int cyc, output int smp);
      cyc = 0;
      smp = 0;
      do begin
         @(posedge mclk);
         cyc++;
         if (sample_hold_sample === 1'b1) smp++;
      end while (conversion_end_irq !== 1'b1 && cyc < 2000);
      check_int(int'(cyc < 2000), 1, "end pulse seen");
   endtask : wait_irq

   task automatic print_verdict;
      $display("counts: checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   initial begin
      #500_000;
      fail_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      print_verdict();
   end

   initial begin
      int         cyc;
      int         smp;
      int         pulses;
      logic [9:0] lvl;
      reset = 1'b1;
      bus_addr = 16'h0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_bit_wr = 1'b0;
      bus_bit_sel = 3'h0;
      bus_bit_val = 1'b0;
      bus_wdata = 8'h00;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      rd(MODE_ADDR);    check16(rd_q, 16'h0000, "mode after reset");
      check16({15'h0000, comparator_power}, 16'h0000, "power after reset");
      rd(WIDE_LO_ADDR); check16(rd_q, 16'h0000, "wide view after reset");
      check_int(waits, 1, "result read wait");
      wr8(MODE_ADDR, 8'h00); check_int(waits, 1, "mode write wait");
      rd(16'hff00);     check16(rd_q, 16'h0000, "unmapped read");
      check_int(waits, 0, "unmapped read wait");
      $display("test reset_and_bus done");

      bitw(MODE_ADDR, CMP_BIT, 1'b1);
      check16({15'h0000, comparator_power}, 16'h0001, "comparator alone powered");
      rd(MODE_ADDR);    check16(rd_q, 16'h0001, "bit write of enable");
      repeat (SETTLE_CYC + 20) @(posedge mclk);
      for (int i = 0; i < 6; i++) begin
         lvl = LEVELS[i*RES_W +: RES_W];
         bitw(MODE_ADDR, RUN_BIT, 1'b0);
         wr8(CHAN_ADDR, 8'(i));
         check16({15'h0000, channel_valid}, 16'h0001, "channel valid");
         wr8(MODE_ADDR, {1'b1, 4'(i), 2'b00, 1'b1});
         wait_irq(cyc, smp);
         wait_irq(cyc, smp);
         check_int(cyc, 22 * DIV_EXP[i], "conversion period");
         check_int(smp, 12 * DIV_EXP[i], "sample phase");
         check16({15'h0000, result_suspect}, 16'h0000, "settled result");
         rd(WIDE_LO_ADDR); check16(rd_q, {lvl, 6'h00}, "wide view");
         rd(WIDE_HI_ADDR); check16(rd_q, {8'h00, lvl[9:2]}, "wide high byte");
         rd(BYTE_ADDR);    check16(rd_q, {8'h00, lvl[9:2]}, "byte view");
      end
      $display("test channel_and_time loop done");

      bitw(MODE_ADDR, RUN_BIT, 1'b0);
      wr8(MODE_ADDR, 8'hc1);
      wait_irq(cyc, smp);
      wait_irq(cyc, smp);
      check_int(cyc, 352, "divide by sixteen period");
      check_int(smp, 192, "divide by sixteen sample phase");
      bitw(MODE_ADDR, RUN_BIT, 1'b0);
      wr8(MODE_ADDR, 8'hab);
      wait_irq(cyc, smp);
      wait_irq(cyc, smp);
      check_int(cyc, 80, "low range period");
      check_int(smp, 60, "low range sample phase");
      // a channel write while running restarts sampling on the new input
      wr8(CHAN_ADDR, 8'h00);
      wait_irq(cyc, smp);
      check_int(cyc, 80, "period after channel restart");
      rd(WIDE_LO_ADDR);
      check16(rd_q, {10'h2b5, 6'h00}, "result of restarted channel");
      bitw(MODE_ADDR, RUN_BIT, 1'b0);
      wr8(CHAN_ADDR, 8'h06);
      check16({15'h0000, channel_valid}, 16'h0000, "code 6 refused");
      wr8(CHAN_ADDR, 8'hff);
      rd(CHAN_ADDR);    check16(rd_q, 16'h0007, "channel upper bits");
      check16({15'h0000, channel_valid}, 16'h0000, "code 7 refused");
      wr8(CHAN_ADDR, 8'h00);
      $display("test range_and_channel done");

      wr8(MODE_ADDR, 8'hab);
      repeat (10) @(posedge mclk);
      bitw(MODE_ADDR, RUN_BIT, 1'b0);
      pulses = 0;
      repeat (200) begin
         @(posedge mclk);
         if (conversion_end_irq !== 1'b0) pulses++;
      end
      check_int(pulses, 0, "no end pulse when stopped");
      rd(MODE_ADDR);    check16(rd_q, 16'h002b, "bit clear of run");
      $display("test abort done");

      wr8(MODE_ADDR, 8'h00);
      check16({15'h0000, comparator_power}, 16'h0000, "fully stopped");
      wr8(MODE_ADDR, 8'ha8);
      check16({15'h0000, comparator_power}, 16'h0001, "run powers comparator");
      wait_irq(cyc, smp);
      check16({15'h0000, result_suspect}, 16'h0001, "first result unsettled");
      rd(WIDE_LO_ADDR); check16(rd_q, {10'h2b5, 6'h00}, "run without enable converts");
      $display("test settle done");

      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      rd(MODE_ADDR);    check16(rd_q, 16'h0000, "mode after second reset");
      rd(BYTE_ADDR);    check16(rd_q, 16'h0000, "byte view after second reset");
      $display("test second_reset done");
      print_verdict();
   end
endmodule : sar_adc_control_tb

`default_nettype wire
